// file: hdl/msfc_pkg.sv
// Purpose: constants and types of the motor stop, speed pulse and fault block
// Assumes: 40 MHz clock, 32-bit classic Wishbone register bus
// Notes:   register offsets are byte addresses of aligned words
package msfc_pkg;
   // register byte offsets
   localparam logic [7:0] MSFC_CTRL_OFS  = 8'h00;
   localparam logic [7:0] MSFC_THR_OFS   = 8'h04;
   localparam logic [7:0] MSFC_CAP_OFS   = 8'h08;
   localparam logic [7:0] MSFC_TIME_OFS  = 8'h0c;
   localparam logic [7:0] MSFC_RETRY_OFS = 8'h10;
   localparam logic [7:0] MSFC_CMD_OFS   = 8'h14;
   localparam logic [7:0] MSFC_STAT_OFS  = 8'h18;
   // reset values and writable masks
   localparam logic [31:0] MSFC_CTRL_RST  = 32'h0000_0100;
   localparam logic [31:0] MSFC_CTRL_MASK = 32'h0000_7fff;
   localparam logic [31:0] MSFC_TIME_MASK = 32'h0000_ffff;
   localparam logic [31:0] MSFC_WORD_RST  = 32'h0000_0000;
   // command bit positions
   localparam int MSFC_CMD_CLR   = 0;
   localparam int MSFC_CMD_STOP  = 1;
   localparam int MSFC_CMD_START = 2;
   // stop method and open-loop policy codes
   localparam logic [2:0] MSFC_STOP_COAST = 3'h0;
   localparam logic [2:0] MSFC_STOP_LSB   = 3'h2;
   localparam logic [2:0] MSFC_STOP_SPIN  = 3'h4;
   localparam logic [1:0] MSFC_OL_HIGH    = 2'h1;
   localparam logic [1:0] MSFC_OL_FIRST   = 2'h2;
   // timing
   localparam int MSFC_CLK_NS = 25;
   localparam int MSFC_MS_NS  = 1000000;
   localparam int MSFC_MS_CYC = MSFC_MS_NS / MSFC_CLK_NS;
   // hysteresis divisor, 5 percent of the cap
   localparam logic [15:0] MSFC_HYST_DIV = 16'h0014;
   // control register layout
   typedef struct packed {
      logic [16:0] rsvd;
      logic        alarm_en;
      logic        act_brake_en;
      logic        cap_en;
      logic [3:0]  divider;
      logic        idle_high;
      logic        fault_high;
      logic [1:0]  ol_policy;
      logic        extent;
      logic [2:0]  method;
   } msfc_ctrl_type;
   // power stage request, all zero is hi-z
   typedef struct packed {
      logic       pwm_en;
      logic [2:0] ls_on;
   } msfc_gate_type;
   // fault condition levels by class
   typedef struct packed {
      logic latched;
      logic retry_slow;
      logic retry_fast;
      logic report;
   } msfc_fault_type;
   typedef enum logic [2:0] {
      MSFC_IDLE,
      MSFC_RUN,
      MSFC_RAMP_BRK,
      MSFC_BRAKE,
      MSFC_RAMP_SPIN,
      MSFC_PIN_RAMP,
      MSFC_PIN_BRAKE
   } msfc_state_type;
endpackage

// file: hdl/msfc_top.sv
// Purpose: stop sequencing, speed pulse, supply current cap, fault pins
// Assumes: speed, emf and current inputs synchronous to clk_i
// Notes:   elec_tick_i pulses twice per electrical cycle
`timescale 1ns/1ps
module msfc_top
   import msfc_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MSFC_MS_CYC
)
(
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   input  wire logic           wb_cyc_i,
   input  wire logic           wb_stb_i,
   input  wire logic           wb_we_i,
   input  wire logic [7:0]     wb_adr_i,
   input  wire logic [3:0]     wb_sel_i,
   input  wire logic [31:0]    wb_dat_i,
   output logic      [31:0]    wb_dat_o,
   output logic                wb_ack_o,
   input  wire logic           brake_pin_i,
   input  wire logic [15:0]    speed_i,
   input  wire logic [15:0]    bemf_i,
   input  wire logic           elec_tick_i,
   input  wire logic           openloop_i,
   input  wire logic           wake_i,
   input  wire msfc_fault_type fault_i,
   input  wire logic [15:0]    bus_current_i,
   input  wire logic [15:0]    speed_ref_i,
   input  wire logic [15:0]    current_ref_i,
   input  wire logic [15:0]    current_meas_i,
   output msfc_gate_type       gate_o,
   output logic                decel_o,
   output logic      [15:0]    ramp_target_o,
   output logic                speed_pulse_out_o,
   output logic                fault_n_out_o,
   output logic                alarm_o,
   output logic      [15:0]    clamped_speed_target_o,
   output logic      [15:0]    clamped_current_target_o
);

   // smaller of two words
   function automatic logic [15:0] msfc_min(input logic [15:0] a,
                                            input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction

   // byte-lane write merge
   function automatic logic [31:0] msfc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      return res;
   endfunction

   msfc_ctrl_type  ctrl_r;
   logic [31:0]    thr_r;
   logic [31:0]    cap_r;
   logic [31:0]    time_r;
   logic [31:0]    retry_r;
   logic           ack_r;
   logic [31:0]    dat_r;
   msfc_state_type state_r;
   msfc_state_type state_nxt;
   logic [15:0]    pre_r;
   logic [15:0]    brk_cnt_r;
   logic [15:0]    retry_cnt_r;
   logic           latched_r;
   logic           limiting_r;
   logic           limiting_nxt;
   msfc_gate_type  gate_r;
   msfc_gate_type  gate_nxt;
   logic           decel_r;
   logic [15:0]    target_r;
   logic [3:0]     div_cnt_r;
   logic           tog_r;
   logic           pulse_r;
   logic           pulse_nxt;
   logic           first_r;
   logic           ol_q_r;
   logic           fault_n_r;
   logic           alarm_r;
   logic [15:0]    clamp_spd_r;
   logic [15:0]    clamp_cur_r;

   // bus decode
   wire        req      = wb_cyc_i & wb_stb_i & ~ack_r;
   wire        wr       = req & wb_we_i;
   wire [7:0]  adr_w    = {wb_adr_i[7:2], 2'h0};
   wire        hit_ctrl = (adr_w == MSFC_CTRL_OFS);
   wire        hit_thr  = (adr_w == MSFC_THR_OFS);
   wire        hit_cap  = (adr_w == MSFC_CAP_OFS);
   wire        hit_time = (adr_w == MSFC_TIME_OFS);
   wire        hit_rty  = (adr_w == MSFC_RETRY_OFS);
   wire        hit_cmd  = (adr_w == MSFC_CMD_OFS);
   wire        hit_stat = (adr_w == MSFC_STAT_OFS);
   wire        cmd_wr   = wr & hit_cmd & wb_sel_i[0];
   wire        clr_cmd  = cmd_wr & wb_dat_i[MSFC_CMD_CLR];
   wire        stop_cmd = cmd_wr & wb_dat_i[MSFC_CMD_STOP];
   wire        start_cmd = cmd_wr & wb_dat_i[MSFC_CMD_START];

   // configuration fields
   wire [15:0] brk_thr   = thr_r[15:0];
   wire [15:0] spin_thr  = thr_r[31:16];
   wire [15:0] cap_val   = cap_r[15:0];
   wire [15:0] emf_floor = cap_r[31:16];
   wire [15:0] brk_ms    = time_r[15:0];
   wire [15:0] fast_ms   = retry_r[15:0];
   wire [15:0] slow_ms   = retry_r[31:16];
   wire        alarm_en  = ctrl_r.alarm_en;
   wire        idle_high = ctrl_r.idle_high;
   wire        flt_high  = ctrl_r.fault_high;
   wire        ab_en     = ctrl_r.act_brake_en;

   // fault classification
   wire        rc         = fault_i.retry_slow | fault_i.retry_fast;
   wire        retry_act  = rc | (retry_cnt_r != 16'h0000);
   wire        actionable = latched_r | retry_act;
   wire        drive_en   = ~actionable;
   wire [15:0] rty_load   = fault_i.retry_slow ? slow_ms : fast_ms;
   wire        ms_tick    = (pre_r == 16'(MS_CYCLES - 1));

   // status word
   wire [31:0] stat_w = {23'h0, alarm_r, fault_n_r, drive_en, retry_act,
                         latched_r, limiting_r, 3'(state_r)};

   // read mux, unmapped reads as zero
   wire [31:0] rd_w = hit_ctrl ? 32'(ctrl_r) :
                      hit_thr  ? thr_r :
                      hit_cap  ? cap_r :
                      hit_time ? time_r :
                      hit_rty  ? retry_r :
                      hit_stat ? stat_w : 32'h0000_0000;

   // bus answer, one cycle after the request
   always_ff @(posedge clk_i)
   begin
      ack_r <= ~rst_i & req;
      dat_r <= rst_i ? 32'h0000_0000 : (req ? rd_w : dat_r);
   end

   // configuration registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r  <= msfc_ctrl_type'(MSFC_CTRL_RST);
         thr_r   <= MSFC_WORD_RST;
         cap_r   <= MSFC_WORD_RST;
         time_r  <= MSFC_WORD_RST;
         retry_r <= MSFC_WORD_RST;
      end
      else if (wr)
      begin
         if (hit_ctrl)
            ctrl_r <= msfc_ctrl_type'(MSFC_CTRL_MASK &
                      msfc_merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
         if (hit_thr)
            thr_r <= msfc_merge(thr_r, wb_dat_i, wb_sel_i);
         if (hit_cap)
            cap_r <= msfc_merge(cap_r, wb_dat_i, wb_sel_i);
         if (hit_time)
            time_r <= MSFC_TIME_MASK &
                      msfc_merge(time_r, wb_dat_i, wb_sel_i);
         if (hit_rty)
            retry_r <= msfc_merge(retry_r, wb_dat_i, wb_sel_i);
      end
   end

   // millisecond prescaler
   always_ff @(posedge clk_i)
   begin
      pre_r <= (rst_i | ms_tick) ? 16'h0000 : pre_r + 16'h0001;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         latched_r <= 1'b0;
      else if (fault_i.latched)
         latched_r <= 1'b1;
      else if (clr_cmd)
         latched_r <= 1'b0;
   end

   // retry wait keeps the longer time
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         retry_cnt_r <= 16'h0000;
      else if (rc)
         retry_cnt_r <= (rty_load > retry_cnt_r) ? rty_load : retry_cnt_r;
      else if (ms_tick && retry_cnt_r != 16'h0000)
         retry_cnt_r <= retry_cnt_r - 16'h0001;
   end

   // stop and brake sequencing
   always_comb
   begin
      state_nxt = state_r;
      if (!drive_en)
         state_nxt = MSFC_IDLE;
      else if (brake_pin_i && state_r != MSFC_PIN_RAMP &&
               state_r != MSFC_PIN_BRAKE)
         state_nxt = (speed_i < brk_thr) ? MSFC_PIN_BRAKE : MSFC_PIN_RAMP;
      else
         case (state_r)
            MSFC_IDLE:
               if (start_cmd)
                  state_nxt = MSFC_RUN;
            MSFC_RUN:
               if (stop_cmd)
                  case (ctrl_r.method)
                     MSFC_STOP_LSB:
                        state_nxt = (speed_i < brk_thr) ? MSFC_BRAKE :
                                    MSFC_RAMP_BRK;
                     MSFC_STOP_SPIN:
                        state_nxt = MSFC_RAMP_SPIN;
                     default:
                        state_nxt = MSFC_IDLE;
                  endcase
            MSFC_RAMP_BRK:
               if (speed_i <= brk_thr)
                  state_nxt = MSFC_BRAKE;
            MSFC_BRAKE:
               if (brk_cnt_r == 16'h0000)
                  state_nxt = MSFC_IDLE;
            MSFC_RAMP_SPIN:
               if (speed_i <= spin_thr)
                  state_nxt = MSFC_IDLE;
            MSFC_PIN_RAMP:
               if (!brake_pin_i)
                  state_nxt = MSFC_IDLE;
               else if (speed_i <= brk_thr)
                  state_nxt = MSFC_PIN_BRAKE;
            MSFC_PIN_BRAKE:
               if (!brake_pin_i)
                  state_nxt = MSFC_IDLE;
            default:
               state_nxt = MSFC_IDLE;
         endcase
   end

   // power stage request from next state
   wire nxt_ramp  = (state_nxt == MSFC_RAMP_BRK) ||
                    (state_nxt == MSFC_RAMP_SPIN) ||
                    (state_nxt == MSFC_PIN_RAMP);
   wire nxt_brake = (state_nxt == MSFC_BRAKE) ||
                    (state_nxt == MSFC_PIN_BRAKE);
   assign gate_nxt.pwm_en = nxt_ramp | (state_nxt == MSFC_RUN);
   assign gate_nxt.ls_on  = {3{nxt_brake}};
   wire brk_entry = (state_nxt == MSFC_BRAKE) && (state_r != MSFC_BRAKE);

   // state, gate and ramp registers
   always_ff @(posedge clk_i)
   begin
      state_r  <= rst_i ? MSFC_IDLE : state_nxt;
      gate_r   <= rst_i ? msfc_gate_type'(0) : gate_nxt;
      decel_r  <= ~rst_i & nxt_ramp;
      target_r <= (rst_i | ~nxt_ramp) ? 16'h0000 :
                  (state_nxt == MSFC_RAMP_SPIN) ? spin_thr : brk_thr;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         brk_cnt_r <= 16'h0000;
      else if (brk_entry)
         brk_cnt_r <= brk_ms;
      else if (ms_tick && brk_cnt_r != 16'h0000)
         brk_cnt_r <= brk_cnt_r - 16'h0001;
   end

   wire [3:0] div_n   = (ctrl_r.divider == 4'h0) ? 4'h1 : ctrl_r.divider;
   wire       div_end = (div_cnt_r + 4'h1) >= div_n;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_cnt_r <= 4'h0;
         tog_r     <= 1'b0;
      end
      else if (elec_tick_i)
      begin
         div_cnt_r <= div_end ? 4'h0 : div_cnt_r + 4'h1;
         tog_r     <= tog_r ^ div_end;
      end
   end

   // first start after power-on or wake, wake wins
   always_ff @(posedge clk_i)
   begin
      ol_q_r <= ~rst_i & openloop_i;
      if (rst_i | wake_i)
         first_r <= 1'b1;
      else if (ol_q_r & ~openloop_i)
         first_r <= 1'b0;
   end

   // pulse extent, driving or emf above floor
   wire pulse_act = gate_r.pwm_en | (ctrl_r.extent & (bemf_i >= emf_floor));
   wire ol_hold = openloop_i & ((ctrl_r.ol_policy == MSFC_OL_HIGH) |
                  ((ctrl_r.ol_policy == MSFC_OL_FIRST) & ~first_r));
   assign pulse_nxt = !drive_en  ? flt_high :
                      !pulse_act ? idle_high :
                      ol_hold    ? 1'b1 : tog_r;

   // release level 5 percent under the cap
   wire [15:0] hyst_lo   = cap_val - (cap_val / MSFC_HYST_DIV);
   wire        cap_allow = ctrl_r.cap_en & ~ab_en;
   assign limiting_nxt = !cap_allow ? 1'b0 :
                         (bus_current_i > cap_val) ? 1'b1 :
                         (bus_current_i < hyst_lo) ? 1'b0 : limiting_r;

   wire fault_n_nxt = ~(actionable | (fault_i.report & ~alarm_en));
   wire alarm_nxt   = alarm_en & (actionable | fault_i.report);

   // output registers
   always_ff @(posedge clk_i)
   begin
      pulse_r    <= ~rst_i & pulse_nxt;
      limiting_r <= ~rst_i & limiting_nxt;
      fault_n_r  <= rst_i | fault_n_nxt;
      alarm_r    <= ~rst_i & alarm_nxt;
   end

   always_ff @(posedge clk_i)
   begin
      clamp_spd_r <= rst_i ? 16'h0000 : (limiting_r ?
                     msfc_min(speed_ref_i, speed_i) : speed_ref_i);
      clamp_cur_r <= rst_i ? 16'h0000 : (limiting_r ?
                     msfc_min(current_ref_i, current_meas_i) : current_ref_i);
   end

   // limiting flag reaches status and outputs
   assign wb_ack_o                 = ack_r;
   assign wb_dat_o                 = dat_r;
   assign gate_o                   = gate_r;
   assign decel_o                  = decel_r;
   assign ramp_target_o            = target_r;
   assign speed_pulse_out_o        = pulse_r;
   assign fault_n_out_o            = fault_n_r;
   assign alarm_o                  = alarm_r;
   assign clamped_speed_target_o   = clamp_spd_r;
   assign clamped_current_target_o = clamp_cur_r;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire go = drive_en & ~brake_pin_i;

   a_coast_stop: assert property (
      (state_r == MSFC_RUN && stop_cmd && go &&
       ctrl_r.method == MSFC_STOP_COAST) |=> (gate_r == msfc_gate_type'(0)))
      else $error("coast stop left a switch on");
   a_lsb_ramp: assert property (
      (state_r == MSFC_RAMP_BRK && go && speed_i <= brk_thr)
      |=> (gate_r.ls_on == 3'h7 && !gate_r.pwm_en))
      else $error("brake not applied after ramp");
   a_lsb_direct: assert property (
      (state_r == MSFC_RUN && stop_cmd && go && speed_i < brk_thr &&
       ctrl_r.method == MSFC_STOP_LSB) |=> (state_r == MSFC_BRAKE))
      else $error("slow motor did not brake at once");
   a_brake_end: assert property (
      (state_r == MSFC_BRAKE && brk_cnt_r == 16'h0000 && go)
      |=> (gate_r == msfc_gate_type'(0)))
      else $error("brake not released to hi-z");
   a_pin_hold: assert property (
      (state_r == MSFC_PIN_BRAKE && brake_pin_i && drive_en) ##1
      (brake_pin_i && drive_en)
      |-> (gate_r.ls_on == 3'h7) ##1 (gate_r.ls_on == 3'h7))
      else $error("pin brake not held");
   a_spin_hiz: assert property (
      (state_r == MSFC_RAMP_SPIN && go && speed_i <= spin_thr)
      |=> (state_r == MSFC_IDLE && gate_r == msfc_gate_type'(0)))
      else $error("spin-down did not end in hi-z");
   a_pulse_fault: assert property (
      !drive_en |=> (speed_pulse_out_o == $past(flt_high)))
      else $error("pulse level wrong in fault");
   a_fault_pin: assert property (
      actionable |=> !fault_n_out_o)
      else $error("fault pin high during fault");
   a_report_only: assert property (
      (!actionable && fault_i.report && alarm_en)
      |=> (fault_n_out_o && alarm_o))
      else $error("report-only fault on wrong pin");
   a_latch_hold: assert property (
      (latched_r && !clr_cmd) |=> (latched_r && !gate_r.pwm_en))
      else $error("latched fault dropped without clear");
   a_slow_retry: assert property (
      (fault_i.retry_slow) |=> (retry_cnt_r >= $past(slow_ms)))
      else $error("retry wait shorter than slow time");
   a_cap_mutex: assert property (
      ab_en |=> !limiting_r)
      else $error("cap active under active braking");
   a_cap_clamp: assert property (
      limiting_r |=> (clamped_speed_target_o <= $past(speed_i)))
      else $error("speed reference not clamped");

endmodule

// file: sim/msfc_motor_model.sv
// Purpose: motor and power stage stand-in for the stop block
// Assumes: speed falls while ramping, rises while driven, stops on brake
// Notes:   emf follows speed, ticks only while the rotor turns
`timescale 1ns/1ps
module msfc_motor_model
   import msfc_pkg::*;
(
   input  wire logic          clk_i,
   input  wire msfc_gate_type gate_i,
   input  wire logic          decel_i,
   input  wire logic [15:0]   target_i,
   output logic      [15:0]   speed_o,
   output logic      [15:0]   bemf_o,
   output logic               tick_o
);
   logic [1:0] ph_r;
   // start spinning at full speed
   initial
   begin
      speed_o = 16'h03e8;
      ph_r = 2'h0;
      tick_o = 1'b0;
   end
   // half-cycle ticks and speed response to the gate request
   always @(posedge clk_i)
   begin
      ph_r <= ph_r + 2'h1;
      tick_o <= (ph_r == 2'h3) && (speed_o != 16'h0000);
      if (decel_i && speed_o > target_i)
         speed_o <= speed_o - 16'h0008;
      else if (gate_i.pwm_en && !decel_i && speed_o < 16'h03e8)
         speed_o <= speed_o + 16'h0008;
      else if (gate_i.ls_on == 3'h7)
         speed_o <= 16'h0000;
   end
   assign bemf_o = speed_o;
endmodule

// file: sim/msfc_top_test.sv
// Purpose: self-checking bench of the stop, speed pulse and fault block
// Assumes: ms tick shortened to 10 clocks
// Notes:   read results are queued by the driver, checked on ack
`timescale 1ns/1ps
`define CK(nm, e, a) \
begin check_count++; if ((a) !== (e)) begin mismatches++; \
$display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
`define WT(c) \
begin n = 0; while (!(c) && n < 2000) begin @(posedge clk_i); n++; end \
if (n == 2000) `CK("wait", 1'b1, 1'b0) end
module msfc_top_test import msfc_pkg::*;;
   logic           clk_i, rst_i, cyc, stb, we, brk, ol, wake, ack;
   logic           tick, decel, pulse, fn, alarm, p;
   logic [7:0]     adr;
   logic [31:0]    wdat, rdat, rnd;
   logic [15:0]    spd, emf, bcur, sref, cref, cmeas, tgt, cst, cct;
   logic [63:0]    note;
   logic [63:0]    notes[$];
   msfc_gate_type  gate;
   msfc_fault_type flt;
   int             mismatches, check_count, n, k;
   msfc_top #(.MS_CYCLES(10)) u_msfc_top (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .brake_pin_i(brk), .speed_i(spd), .bemf_i(emf), .elec_tick_i(tick),
      .openloop_i(ol), .wake_i(wake), .fault_i(flt), .bus_current_i(bcur),
      .speed_ref_i(sref), .current_ref_i(cref), .current_meas_i(cmeas),
      .gate_o(gate), .decel_o(decel), .ramp_target_o(tgt),
      .speed_pulse_out_o(pulse), .fault_n_out_o(fn), .alarm_o(alarm),
      .clamped_speed_target_o(cst), .clamped_current_target_o(cct));
   msfc_motor_model u_msfc_motor_model (.clk_i(clk_i), .gate_i(gate),
      .decel_i(decel), .target_i(tgt), .speed_o(spd), .bemf_o(emf),
      .tick_o(tick));
   // clock of 25 ns
   always #12.5 clk_i = ~clk_i;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one classic cycle; reads leave {mask, expected} in the queue
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      if (!w)
         notes.push_back({m, d & m});
      `WT(ack === 1'b1)
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // compare read data with the oldest note when ack is sampled
   always @(posedge clk_i)
   begin
      if (ack === 1'b1 && cyc && !we)
      begin
         note = notes.pop_front();
         `CK("rdat", note[31:0], rdat & note[63:32])
      end
   end
   // hang guard, far above the expected run length
   initial
   begin
      #500000;
      mismatches++;
      finish_test();
   end
   initial
   begin
      {clk_i, rst_i, cyc, stb, we, brk, ol, wake} = 8'h40;
      {adr, wdat, flt, bcur, sref, cref, cmeas} = '0;
      rnd = 32'he7f7;
      mismatches = 0;
      check_count = 0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // register map, reserved bits, unmapped and write-only places
      bus(0, MSFC_CTRL_OFS, MSFC_CTRL_RST, 32'hffff_ffff);
      bus(0, 8'h1c, 32'h0, 32'hffff_ffff);
      bus(1, MSFC_CTRL_OFS, 32'hffff_ffff, 32'h0);
      bus(0, MSFC_CTRL_OFS, MSFC_CTRL_MASK, 32'hffff_ffff);
      bus(0, MSFC_CMD_OFS, 32'h0, 32'hffff_ffff);
      bus(0, MSFC_STAT_OFS, 32'hc0, 32'h1ff);
      bus(1, MSFC_THR_OFS, 32'h012c_01f4, 32'h0);
      bus(1, MSFC_TIME_OFS, 32'h3, 32'h0);
      $display("test registers done");
      bus(1, MSFC_CTRL_OFS, 32'h100, 32'h0);
      bus(1, MSFC_CMD_OFS, 32'h4, 32'h0);
      bus(1, MSFC_CMD_OFS, 32'h2, 32'h0);
      `CK("coast", 4'h0, gate)
      // low-side brake after ramp, then hi-z
      bus(1, MSFC_CTRL_OFS, 32'h102, 32'h0);
      bus(1, MSFC_CMD_OFS, 32'h4, 32'h0);
      bus(1, MSFC_CMD_OFS, 32'h2, 32'h0);
      `CK("target", 16'h01f4, tgt)
      `WT(gate.ls_on == 3'h7)
      `CK("brk_speed", 1'b1, spd <= 16'h01f4)
      `WT(gate == 4'h0)
      `CK("brk_len", 1'b1, n >= 15 && n <= 31)
      bus(1, MSFC_CMD_OFS, 32'h4, 32'h0);
      bus(1, MSFC_CMD_OFS, 32'h2, 32'h0);
      `CK("brk_now", 3'h7, gate.ls_on)
      `WT(gate == 4'h0)
      $display("test brake stop done");
      bus(1, MSFC_CTRL_OFS, 32'h104, 32'h0);
      bus(1, MSFC_CMD_OFS, 32'h4, 32'h0);
      repeat (150) @(posedge clk_i);
      bus(1, MSFC_CMD_OFS, 32'h2, 32'h0);
      `CK("spin_tgt", 16'h012c, tgt)
      `WT(gate == 4'h0)
      `CK("spin_spd", 1'b1, spd <= 16'h012c)
      // brake pin ramps, brakes and holds
      bus(1, MSFC_CMD_OFS, 32'h4, 32'h0);
      repeat (100) @(posedge clk_i);
      brk <= 1'b1;
      `WT(gate.ls_on == 3'h7)
      `CK("pin_spd", 1'b1, spd <= 16'h01f4)
      repeat (40) @(posedge clk_i);
      `CK("pin_hold", 3'h7, gate.ls_on)
      brk <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CK("pin_off", 4'h0, gate)
      $display("test spin and pin done");
      // idle level, emf floor, divider of three, open loop
      bus(1, MSFC_CAP_OFS, 32'h0001_0000, 32'h0);
      bus(1, MSFC_CTRL_OFS, 32'h388, 32'h0);
      `CK("idle_lvl", 1'b1, pulse)
      bus(1, MSFC_CMD_OFS, 32'h4, 32'h0);
      // skip the idle-to-drive step, count from a real toggle
      repeat (2)
      begin
         p = pulse;
         `WT(pulse !== p)
      end
      p = pulse;
      k = 0;
      while (pulse === p && k < 100)
      begin
         @(posedge clk_i);
         k += (tick === 1'b1);
      end
      `CK("div_ticks", 3, k)
      // coast stop, pulse goes on while emf stays above the floor
      bus(1, MSFC_CMD_OFS, 32'h2, 32'h0);
      repeat (2)
      begin
         p = pulse;
         `WT(pulse !== p)
      end
      `CK("extent", 1'b1, n < 2000)
      bus(1, MSFC_CTRL_OFS, 32'h398, 32'h0);
      ol <= 1'b1;
      repeat (3)
      begin
         repeat (5) @(posedge clk_i);
         `CK("ol_high", 1'b1, pulse)
      end
      ol <= 1'b0;
      // first-start policy: later start holds high, wake restores follow
      bus(1, MSFC_CTRL_OFS, 32'h3a8, 32'h0);
      ol <= 1'b1;
      repeat (5) @(posedge clk_i);
      `CK("ol_later", 1'b1, pulse)
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      `WT(pulse === 1'b0)
      `CK("ol_first", 1'b0, pulse)
      ol <= 1'b0;
      $display("test speed pulse done");
      bus(1, MSFC_CTRL_OFS, 32'h4040, 32'h0);
      flt <= 4'b1000;
      repeat (3) @(posedge clk_i);
      `CK("fault_n", 1'b0, fn)
      `CK("flt_lvl", 1'b1, pulse)
      `CK("alarm", 1'b1, alarm)
      `CK("gate_off", 1'b0, gate.pwm_en)
      flt <= 4'b0000;
      repeat (5) @(posedge clk_i);
      bus(0, MSFC_STAT_OFS, 32'h10, 32'h90);
      bus(1, MSFC_CMD_OFS, 32'h1, 32'h0);
      `WT(fn === 1'b1)
      // report-only with and without alarm pin
      flt <= 4'b0001;
      repeat (3) @(posedge clk_i);
      `CK("rep_fn", 1'b1, fn)
      `CK("rep_alarm", 1'b1, alarm)
      bus(1, MSFC_CTRL_OFS, 32'h0, 32'h0);
      `CK("rep_fn0", 1'b0, fn)
      flt <= 4'b0000;
      // slow retry time wins over fast
      bus(1, MSFC_RETRY_OFS, 32'h0005_0001, 32'h0);
      flt <= 4'b0110;
      @(posedge clk_i);
      flt <= 4'b0000;
      repeat (25) @(posedge clk_i);
      bus(0, MSFC_STAT_OFS, 32'h20, 32'h20);
      repeat (60) @(posedge clk_i);
      bus(0, MSFC_STAT_OFS, 32'h40, 32'h60);
      $display("test faults done");
      sref <= 16'h1388;
      cref <= 16'h0fa0;
      cmeas <= 16'h04d2;
      bus(1, MSFC_CAP_OFS, 32'h3e8, 32'h0);
      bus(1, MSFC_CTRL_OFS, 32'h1000, 32'h0);
      rnd = xs(rnd);
      bcur <= 16'h03e9 + {9'h0, rnd[6:0]};
      repeat (3) @(posedge clk_i);
      bus(0, MSFC_STAT_OFS, 32'h8, 32'h8);
      `CK("clamp", spd, cst)
      `CK("clamp_cur", 16'h04d2, cct)
      bcur <= 16'h03b6;
      repeat (3) @(posedge clk_i);
      bus(0, MSFC_STAT_OFS, 32'h8, 32'h8);
      bcur <= 16'h03b5;
      repeat (3) @(posedge clk_i);
      bus(0, MSFC_STAT_OFS, 32'h0, 32'h8);
      `CK("no_clamp", 16'h1388, cst)
      `CK("no_clamp_cur", 16'h0fa0, cct)
      bus(1, MSFC_CTRL_OFS, 32'h3000, 32'h0);
      bcur <= 16'h07d0;
      repeat (3) @(posedge clk_i);
      bus(0, MSFC_STAT_OFS, 32'h0, 32'h8);
      $display("test supply cap done");
      finish_test();
   end
endmodule
